//--- src/mux_glue_defs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef MUX_GLUE_DEFS_SVH
`define MUX_GLUE_DEFS_SVH

`define MCLK_HZ 125000000
`define TIMER_BASE_HZ 1843200

`define REG_READY_FN 8'h00
`define REG_HOOD_LAMP 8'h05
`define REG_STATUS 8'h08
`define REG_MEM_CFG 8'h09
`define REG_RTC 8'h0A
`define REG_TIMER_LO 8'h10
`define REG_TIMER_HI 8'h1B
`define REG_BP_CTRL 8'h20
`define REG_BP_DATA 8'h21
`define REG_BP_ADDR 8'h22

`define LAMP_BIT 7
`define EXT_IRQ_EN_BIT 6
`define DMA_B_EN_BIT 7
`define RTC_EN_BIT 0
`define RTC_PEND_BIT 1
`define BP_DIR_BIT 0
`define BP_END_BIT 1
`define BP_FLUSH_BIT 2

`define READY_FN_RESET 2'h0
`define MEM_CFG_RESET 2'h0
`define UNARY_ADDR_RESET 4'h0

`endif

//--- src/mux_glue_pkg.sv
// Types shared by the card glue modules
package mux_glue_pkg;
	typedef enum logic {
		BP_FROM_HOST = 1'b0,
		BP_TO_HOST = 1'b1
	} bp_dir_t;
	typedef enum logic {
		PHASE_LOW = 1'b0,
		PHASE_HIGH = 1'b1
	} byte_phase_t;
endpackage

//--- src/pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk, // System clock
	input wire logic [WIDTH-1:0] pin, // Asynchronous pin levels
	output logic [WIDTH-1:0] level // Filtered synchronous levels
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic stage1;
			logic stage2;
			logic stage3;
			logic filtered;
			always_ff @(posedge mclk) begin
				stage1 <= pin[i];
				stage2 <= stage1;
				stage3 <= stage2;
				if (stage2 == stage3) begin
					filtered <= stage3;
				end
			end
			assign level[i] = filtered;
		end
	endgenerate
endmodule

//--- src/counter_timer_unit.sv
// Four-channel down-counter unit clocked by the shared base-rate enable
`timescale 1ns/1ps
module counter_timer_unit #(
	parameter int CHANNELS = 4,
	parameter bit IRQ_CAPABLE = 1'b1
) (
	input wire logic mclk, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic tick, // Base-rate enable pulse
	input wire logic load, // Time-constant write strobe
	input wire logic [1:0] load_ch, // Channel being written
	input wire logic [7:0] load_value, // Time constant, zero means 256
	input wire logic irq_enable, // Last channel interrupt enable
	output logic [CHANNELS-2:0] zero_out, // Zero-count pulses
	output logic irq_pulse, // Last channel interrupt pulse
	output logic [8*CHANNELS-1:0] count_flat // Live counts
);
	logic [CHANNELS-1:0] zero_hit;

	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++) begin : g_ch
			logic [7:0] time_const;
			logic [7:0] count;
			logic running;
			logic hit;
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					time_const <= 8'h00;
					count <= 8'h00;
					running <= 1'b0;
					hit <= 1'b0;
				end else if (load && load_ch == 2'(c)) begin
					time_const <= load_value;
					count <= load_value;
					running <= 1'b1;
					hit <= 1'b0;
				end else begin
					hit <= tick && running && count == 8'h01;
					if (tick && running) begin
						count <= (count == 8'h01) ? time_const : count - 8'h01;
					end
				end
			end
			assign zero_hit[c] = hit;
			assign count_flat[8*c +: 8] = count;
		end
	endgenerate

	// Only the first channels reach pins; the last one can only interrupt
	assign zero_out = zero_hit[CHANNELS-2:0];
	assign irq_pulse = IRQ_CAPABLE && irq_enable && zero_hit[CHANNELS-1];
endmodule

//--- src/mux_card_local_io_glue.sv
// Local I/O glue: serial special pins, timers, backplane unit, interrupts
//
// Function
// - Hood sense low when fitted, high when absent, also after reset.
// - Port A ready of serial controller 0 drives DMA request input two.
// - Ready pin in ready function flags that the port can move a byte.
// - Both DMA ready lines float after reset until software enables them.
// - Port B ready of serial controller 0 drives DMA request input zero.
// - Hood lamp output is off after reset.
// - No modem control or status pins are used for handshaking.
// - Each timer unit has four channels; three drive pins, one interrupts in unit 0.
// - Only timer unit 0 interrupts; units 1 and 2 only make baud clocks.
// - Unit 0 channel 3 is the firmware tick, interrupting at each zero.
// - All timer channels count from the common 1.8432 MHz base clock.
// - Unit 0 channel 0 drives the DMA request hold-off input.
// - Baud outputs map to port receive and transmit clocks as tabled.
// - Channel 3 of units 1 and 2 has no pin but can be polled.
// - Backplane unit registers are reached as processor I/O ports.
// - DMA channel B moves data between the backplane unit and memory.
// - Backplane interrupt feeds memory unit external input, not the chain.
// - Backplane data path is half duplex, one direction at a time.
// - Backplane ready is asserted whenever the unit can transfer locally.
// - Unary address is latched after power-on or interface clear.
// - Odd-byte flags mark a 16-bit transfer ending with an odd byte.
// - External interrupt is sensed only while enable bit 6 is set.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "mux_glue_defs.svh"
module mux_card_local_io_glue
	import mux_glue_pkg::*;
(
	input wire logic mclk, // 125 MHz system clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [7:0] addr, // Register address
	input wire logic [7:0] wdata, // Register write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after rd
	input wire logic port0_can_xfer, // Card port 0 can move a byte
	input wire logic port1_can_xfer, // Card port 1 can move a byte
	output logic dma_request_two_n, // Port 0 ready pin level
	output logic dma_request_two_oe_n, // Port 0 ready pin enable, low drives
	output logic dma_request_zero_n, // Port 1 ready pin level
	output logic dma_request_zero_oe_n, // Port 1 ready pin enable, low drives
	output logic hood_lamp_n, // Diagnostic hood lamp, active low
	input wire logic hood_sense_n, // Hood sense pin, low when fitted
	output logic [7:0] port_baud_clock, // Per-port rx and tx clock pulses
	output logic dma_holdoff, // DMA request hold-off
	output logic processor_irq_n, // Interrupt to local processor
	output logic mem_dma_b_req_n, // DMA channel B request
	input wire logic [15:0] bp_data_in, // Backplane data from host
	output logic [15:0] bp_data_out, // Backplane data to host
	output logic bp_data_oe_n, // Backplane data enable, low drives
	input wire logic bp_strobe, // Host transfer strobe
	input wire logic channel_odd_byte, // Host word ends with odd byte
	output logic device_odd_byte, // Card word ends with odd byte
	output logic backplane_ready_n, // Backplane unit ready, active low
	input wire logic [3:0] unary_channel_addr, // Unary address pins
	input wire logic primary_power_on, // Primary power-on event pin
	input wire logic interface_clear // Interface clear event pin
);
	localparam int SYNC_W = 25;

	function automatic logic is_timer(input logic [7:0] a);
		return a >= `REG_TIMER_LO && a <= `REG_TIMER_HI;
	endfunction

	logic [SYNC_W-1:0] sync_level;
	logic hood_sense_s;
	logic strobe_s;
	logic chan_odd_s;
	logic power_on_s;
	logic if_clear_s;
	logic [3:0] unary_s;
	logic [15:0] bp_in_s;
	logic strobe_d;
	logic power_on_d;
	logic if_clear_d;
	logic strobe_rise;
	logic latch_event;
	logic [1:0] ready_fn;
	logic ext_irq_enable;
	logic dma_b_enable;
	logic rtc_enable;
	logic rtc_pending;
	logic [26:0] phase_acc;
	logic timer_tick;
	logic [2:0] zero_out [3];
	logic [2:0] irq_pulse;
	logic [8*4-1:0] count_flat [3];
	bp_dir_t bp_dir;
	byte_phase_t phase;
	logic out_full;
	logic in_full;
	logic in_odd;
	logic [15:0] in_word;
	logic [3:0] unary_latched;
	logic next_ready;
	logic external_irq_in_n;
	logic flush;

	pin_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.mclk(mclk),
		.pin({hood_sense_n, bp_strobe, channel_odd_byte, primary_power_on,
			interface_clear, unary_channel_addr, bp_data_in}),
		.level(sync_level)
	);
	assign {hood_sense_s, strobe_s, chan_odd_s, power_on_s, if_clear_s,
		unary_s, bp_in_s} = sync_level;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			strobe_d <= 1'b0;
			power_on_d <= 1'b0;
			if_clear_d <= 1'b0;
		end else begin
			strobe_d <= strobe_s;
			power_on_d <= power_on_s;
			if_clear_d <= if_clear_s;
		end
	end
	assign strobe_rise = strobe_s && !strobe_d;
	assign latch_event = (power_on_s && !power_on_d) ||
		(if_clear_s && !if_clear_d);

	// Software control registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ready_fn <= `READY_FN_RESET;
			hood_lamp_n <= 1'b1;
			ext_irq_enable <= 1'b0;
			dma_b_enable <= 1'b0;
			rtc_enable <= 1'b0;
		end else if (wr) begin
			case (addr)
				`REG_READY_FN: ready_fn <= wdata[1:0];
				`REG_HOOD_LAMP: hood_lamp_n <= !wdata[`LAMP_BIT];
				`REG_MEM_CFG: begin
					ext_irq_enable <= wdata[`EXT_IRQ_EN_BIT];
					dma_b_enable <= wdata[`DMA_B_EN_BIT];
				end
				`REG_RTC: rtc_enable <= wdata[`RTC_EN_BIT];
				default: ;
			endcase
		end
	end

	// Ready pins float until the ready function is chosen; no modem use
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dma_request_two_oe_n <= 1'b1;
			dma_request_zero_oe_n <= 1'b1;
			dma_request_two_n <= 1'b1;
			dma_request_zero_n <= 1'b1;
		end else begin
			dma_request_two_oe_n <= !ready_fn[0];
			dma_request_zero_oe_n <= !ready_fn[1];
			dma_request_two_n <= !(ready_fn[0] && port0_can_xfer);
			dma_request_zero_n <= !(ready_fn[1] && port1_can_xfer);
		end
	end

	// Fractional divider makes the 1.8432 MHz base enable from mclk
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			phase_acc <= 27'h0000000;
			timer_tick <= 1'b0;
		end else if (phase_acc >= 27'(`MCLK_HZ - `TIMER_BASE_HZ)) begin
			phase_acc <= phase_acc - 27'(`MCLK_HZ - `TIMER_BASE_HZ);
			timer_tick <= 1'b1;
		end else begin
			phase_acc <= phase_acc + 27'(`TIMER_BASE_HZ);
			timer_tick <= 1'b0;
		end
	end

	genvar u;
	generate
		for (u = 0; u < 3; u++) begin : g_unit
			counter_timer_unit #(
				.CHANNELS(4),
				.IRQ_CAPABLE(u == 0)
			) u_timer (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.tick(timer_tick),
				.load(wr && is_timer(addr) && addr[3:2] == 2'(u)),
				.load_ch(addr[1:0]),
				.load_value(wdata),
				.irq_enable(u == 0 && rtc_enable),
				.zero_out(zero_out[u]),
				.irq_pulse(irq_pulse[u]),
				.count_flat(count_flat[u])
			);
		end
	endgenerate

	// Baud and hold-off pins
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			port_baud_clock <= 8'h00;
			dma_holdoff <= 1'b0;
		end else begin
			port_baud_clock <= {zero_out[2], zero_out[1],
				zero_out[0][1], zero_out[0][2]};
			dma_holdoff <= zero_out[0][0];
		end
	end

	// Firmware tick pending flag; a new tick wins over the clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rtc_pending <= 1'b0;
		end else if (irq_pulse[0]) begin
			rtc_pending <= 1'b1;
		end else if (wr && addr == `REG_RTC && wdata[`RTC_PEND_BIT]) begin
			rtc_pending <= 1'b0;
		end
	end

	// Backplane interrupt goes to the memory unit input, gated by its enable
	assign external_irq_in_n = !in_full;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			processor_irq_n <= 1'b1;
		end else begin
			processor_irq_n <= !(rtc_pending ||
				(ext_irq_enable && !external_irq_in_n));
		end
	end

	assign flush = latch_event ||
		(wr && addr == `REG_BP_CTRL &&
		(wdata[`BP_FLUSH_BIT] || wdata[`BP_DIR_BIT] != bp_dir));

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			unary_latched <= `UNARY_ADDR_RESET;
		end else if (latch_event) begin
			unary_latched <= unary_s;
		end
	end

	// Half-duplex byte pairing between local bus and backplane words
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bp_dir <= BP_FROM_HOST;
			phase <= PHASE_LOW;
			out_full <= 1'b0;
			in_full <= 1'b0;
			in_odd <= 1'b0;
			in_word <= 16'h0000;
			bp_data_out <= 16'h0000;
			device_odd_byte <= 1'b0;
		end else if (flush) begin
			if (wr && addr == `REG_BP_CTRL) begin
				bp_dir <= bp_dir_t'(wdata[`BP_DIR_BIT]);
			end
			phase <= PHASE_LOW;
			out_full <= 1'b0;
			in_full <= 1'b0;
			device_odd_byte <= 1'b0;
		end else if (bp_dir == BP_TO_HOST) begin
			if (out_full && strobe_rise) begin
				out_full <= 1'b0;
				device_odd_byte <= 1'b0;
			end else if (!out_full && wr && addr == `REG_BP_DATA) begin
				if (phase == PHASE_LOW) begin
					bp_data_out[7:0] <= wdata;
					phase <= PHASE_HIGH;
				end else begin
					bp_data_out[15:8] <= wdata;
					out_full <= 1'b1;
					phase <= PHASE_LOW;
				end
			end else if (!out_full && wr && addr == `REG_BP_CTRL &&
				wdata[`BP_END_BIT] && phase == PHASE_HIGH) begin
				out_full <= 1'b1;
				device_odd_byte <= 1'b1;
				phase <= PHASE_LOW;
			end
		end else begin
			if (!in_full && strobe_rise) begin
				in_word <= bp_in_s;
				in_odd <= chan_odd_s;
				in_full <= 1'b1;
				phase <= PHASE_LOW;
			end else if (in_full && rd && addr == `REG_BP_DATA) begin
				if (phase == PHASE_LOW && !in_odd) begin
					phase <= PHASE_HIGH;
				end else begin
					in_full <= 1'b0;
					phase <= PHASE_LOW;
				end
			end
		end
	end

	assign next_ready = (bp_dir == BP_TO_HOST) ? !out_full : in_full;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			backplane_ready_n <= 1'b1;
			bp_data_oe_n <= 1'b1;
			mem_dma_b_req_n <= 1'b1;
		end else begin
			backplane_ready_n <= !next_ready;
			bp_data_oe_n <= !(bp_dir == BP_TO_HOST && out_full);
			mem_dma_b_req_n <= !(dma_b_enable && next_ready);
		end
	end

	// Read data stands in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			if (is_timer(addr)) begin
				rdata <= count_flat[addr[3:2]][8*addr[1:0] +: 8];
			end else begin
				case (addr)
					`REG_READY_FN: rdata <= {6'h00, ready_fn};
					`REG_HOOD_LAMP: rdata <= {!hood_lamp_n, 7'h00};
					`REG_STATUS: rdata <= {2'h0, device_odd_byte, in_full,
						out_full, port1_can_xfer, port0_can_xfer,
						hood_sense_s};
					`REG_MEM_CFG: rdata <= {dma_b_enable, ext_irq_enable, 6'h00};
					`REG_RTC: rdata <= {6'h00, rtc_pending, rtc_enable};
					`REG_BP_CTRL: rdata <= {5'h00, in_odd, phase, bp_dir};
					`REG_BP_DATA: rdata <= (phase == PHASE_LOW) ?
						in_word[7:0] : in_word[15:8];
					`REG_BP_ADDR: rdata <= {4'h0, unary_latched};
					default: rdata <= 8'h00;
				endcase
			end
		end else begin
			rdata <= 8'h00;
		end
	end

	a_lamp_reset: assert property (@(posedge mclk)
		sys_rst |=> hood_lamp_n) else $error("hood lamp lit after reset");
	a_ready_float: assert property (@(posedge mclk)
		sys_rst |=> dma_request_two_oe_n && dma_request_zero_oe_n)
		else $error("ready pins driven after reset");
	a_port0_ready: assert property (@(posedge mclk) disable iff (sys_rst)
		ready_fn[0] && port0_can_xfer |=> !dma_request_two_n &&
		!dma_request_two_oe_n) else $error("port 0 ready not asserted");
	a_port1_ready: assert property (@(posedge mclk) disable iff (sys_rst)
		!ready_fn[1] |=> dma_request_zero_oe_n && dma_request_zero_n)
		else $error("port 1 ready driven while disabled");
	a_holdoff_map: assert property (@(posedge mclk) disable iff (sys_rst)
		dma_holdoff == $past(zero_out[0][0]))
		else $error("hold-off does not follow unit 0 channel 0");
	a_baud_map: assert property (@(posedge mclk) disable iff (sys_rst)
		zero_out[0][2] && !$past(sys_rst) |=> port_baud_clock[0])
		else $error("port 0 baud clock missing");
	a_rtc_irq: assert property (@(posedge mclk) disable iff (sys_rst)
		irq_pulse[0] |=> rtc_pending ##1 !processor_irq_n)
		else $error("tick did not interrupt");
	a_ext_masked: assert property (@(posedge mclk) disable iff (sys_rst)
		!ext_irq_enable && !rtc_pending |=> processor_irq_n)
		else $error("external interrupt passed while disabled");
	a_half_duplex: assert property (@(posedge mclk) disable iff (sys_rst)
		!bp_data_oe_n |-> $past(bp_dir) == BP_TO_HOST)
		else $error("backplane driven in receive direction");
	a_bp_ready: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst) |-> backplane_ready_n == !$past(next_ready))
		else $error("backplane ready wrong");
	a_odd_byte: assert property (@(posedge mclk) disable iff (sys_rst)
		device_odd_byte |-> out_full)
		else $error("odd byte flag without a word");

	c_rtc_fire: cover property (@(posedge mclk) irq_pulse[0]);
	c_word_out: cover property (@(posedge mclk) out_full && strobe_rise);
	c_word_in: cover property (@(posedge mclk) !in_full && strobe_rise &&
		bp_dir == BP_FROM_HOST);
	c_port0_dma: cover property (@(posedge mclk) !dma_request_two_n);
endmodule

//--- test/host_channel_model.sv
// Host backplane channel model: moves words by strobe, raises address events
`timescale 1ns/1ps
module host_channel_model (
	input wire logic mclk, // System clock
	input wire logic [15:0] bp_data_out, // Word from card
	input wire logic bp_data_oe_n, // Card drives the word when low
	output logic [15:0] bp_data_in, // Word to card
	output logic bp_strobe, // Host transfer strobe
	output logic channel_odd_byte, // Host word ends with odd byte
	output logic [3:0] unary_channel_addr, // Unary address pins
	output logic primary_power_on, // Power-on event
	output logic interface_clear // Interface clear event
);
	initial begin
		bp_data_in = 16'hFFFF;
		bp_strobe = 1'b0;
		channel_odd_byte = 1'b0;
		unary_channel_addr = 4'h0;
		primary_power_on = 1'b0;
		interface_clear = 1'b0;
	end

	// Levels are held long enough for the card's three-stage filters
	task automatic hold(input int cycles);
		repeat (cycles) @(posedge mclk);
	endtask

	// Released data lines show the inverse so stale values never pass
	task automatic send_word(input logic [15:0] w, input logic odd);
		@(posedge mclk);
		bp_data_in <= w;
		channel_odd_byte <= odd;
		hold(5);
		bp_strobe <= 1'b1;
		hold(6);
		bp_strobe <= 1'b0;
		bp_data_in <= ~w;
		channel_odd_byte <= ~odd;
		hold(6);
	endtask

	// Host takes the word the card holds; only one direction at a time
	task automatic take_word();
		@(posedge mclk);
		if (bp_data_oe_n === 1'b0) begin
			bp_strobe <= 1'b1;
		end
		hold(6);
		bp_strobe <= 1'b0;
		hold(6);
	endtask

	task automatic addr_event(input logic [3:0] a, input logic clear);
		@(posedge mclk);
		unary_channel_addr <= a;
		hold(5);
		if (clear) begin
			interface_clear <= 1'b1;
		end else begin
			primary_power_on <= 1'b1;
		end
		hold(6);
		interface_clear <= 1'b0;
		primary_power_on <= 1'b0;
		hold(6);
	endtask
endmodule

//--- test/mux_card_local_io_glue_tb.sv
// Self-checking bench for the card local I/O glue
`timescale 1ns/1ps
`include "mux_glue_defs.svh"
module mux_card_local_io_glue_tb
	import mux_glue_pkg::*;
;
	logic mclk, sys_rst, wr, rd, port0_can_xfer, port1_can_xfer;
	logic hood_sense_n, hood_lamp_n, dma_holdoff, processor_irq_n;
	logic dma_request_two_n, dma_request_two_oe_n, mem_dma_b_req_n;
	logic dma_request_zero_n, dma_request_zero_oe_n, bp_data_oe_n;
	logic bp_strobe, channel_odd_byte, device_odd_byte, backplane_ready_n;
	logic primary_power_on, interface_clear, quiet;
	logic [7:0] addr, wdata, rdata, port_baud_clock, d, d2;
	logic [15:0] bp_data_in, bp_data_out;
	logic [3:0] unary_channel_addr;
	logic [8:0] tout;
	logic [7:0] tmr_off [9] = '{8'h00, 8'h02, 8'h01, 8'h04, 8'h05, 8'h06,
		8'h08, 8'h09, 8'h0A};
	int bad_count, checked, cycles, n;
	int lo = 3 * `MCLK_HZ / `TIMER_BASE_HZ - 1;

	assign tout = {dma_holdoff, port_baud_clock};

	mux_card_local_io_glue mux_card_local_io_glue_i (
		.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .port0_can_xfer(port0_can_xfer),
		.port1_can_xfer(port1_can_xfer),
		.dma_request_two_n(dma_request_two_n),
		.dma_request_two_oe_n(dma_request_two_oe_n),
		.dma_request_zero_n(dma_request_zero_n),
		.dma_request_zero_oe_n(dma_request_zero_oe_n),
		.hood_lamp_n(hood_lamp_n), .hood_sense_n(hood_sense_n),
		.port_baud_clock(port_baud_clock), .dma_holdoff(dma_holdoff),
		.processor_irq_n(processor_irq_n),
		.mem_dma_b_req_n(mem_dma_b_req_n), .bp_data_in(bp_data_in),
		.bp_data_out(bp_data_out), .bp_data_oe_n(bp_data_oe_n),
		.bp_strobe(bp_strobe), .channel_odd_byte(channel_odd_byte),
		.device_odd_byte(device_odd_byte),
		.backplane_ready_n(backplane_ready_n),
		.unary_channel_addr(unary_channel_addr),
		.primary_power_on(primary_power_on),
		.interface_clear(interface_clear)
	);

	host_channel_model host_channel_model_i (
		.mclk(mclk), .bp_data_out(bp_data_out), .bp_data_oe_n(bp_data_oe_n),
		.bp_data_in(bp_data_in), .bp_strobe(bp_strobe),
		.channel_odd_byte(channel_odd_byte),
		.unary_channel_addr(unary_channel_addr),
		.primary_power_on(primary_power_on),
		.interface_clear(interface_clear)
	);

	always #4 mclk = ~mclk;

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			results();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return bp_data_oe_n;
			1: return backplane_ready_n;
			default: return processor_irq_n;
		endcase
	endfunction

	task automatic wait_lvl(input string what, input int sel,
		input logic lvl, input int lim);
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (pick(sel) !== lvl && n < lim);
		check(what, pick(sel), lvl);
	endtask

	task automatic wait_pulse();
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (tout === 9'h000 && n < 700);
	endtask

	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		port0_can_xfer = 1'b0;
		port1_can_xfer = 1'b0;
		hood_sense_n = 1'b1;
		bad_count = 0;
		checked = 0;
		cycles = 0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		check("lamp reset", hood_lamp_n, 1'b1);
		check("rdy0 float", dma_request_two_oe_n, 1'b1);
		check("rdy1 float", dma_request_zero_oe_n, 1'b1);
		rd_reg(`REG_STATUS);
		check("sense absent", d[0], 1'b1);
		$display("test reset done");

		wr_reg(`REG_HOOD_LAMP, 8'h80);
		check("lamp on", hood_lamp_n, 1'b0);
		@(posedge mclk);
		hood_sense_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rd_reg(`REG_STATUS);
		check("sense fitted", d[0], 1'b0);
		wr_reg(`REG_HOOD_LAMP, 8'h00);
		check("lamp off", hood_lamp_n, 1'b1);
		$display("test hood done");

		@(posedge mclk);
		port0_can_xfer <= 1'b1;
		wr_reg(`REG_READY_FN, 8'h03);
		repeat (2) @(posedge mclk);
		#1;
		check("rdy0 driven", dma_request_two_oe_n, 1'b0);
		check("rdy1 driven", dma_request_zero_oe_n, 1'b0);
		check("rdy0", dma_request_two_n, 1'b0);
		check("rdy1 idle", dma_request_zero_n, 1'b1);
		@(posedge mclk);
		port0_can_xfer <= 1'b0;
		port1_can_xfer <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		check("rdy0 idle", dma_request_two_n, 1'b1);
		check("rdy1", dma_request_zero_n, 1'b0);
		rd_reg(`REG_STATUS);
		check("can xfer", d[2:1], 2'b10);
		$display("test ready done");

		wr_reg(`REG_RTC, 8'h01);
		wr_reg(`REG_TIMER_LO + 8'h07, 8'h01);
		wr_reg(`REG_TIMER_LO + 8'h0B, 8'hC8);
		quiet = 1'b1;
		repeat (300) begin
			@(posedge mclk);
			#1;
			if (processor_irq_n !== 1'b1) quiet = 1'b0;
		end
		check("no unit1 2 irq", quiet, 1'b1);
		rd_reg(`REG_TIMER_LO + 8'h0B);
		d2 = d;
		repeat (150) @(posedge mclk);
		rd_reg(`REG_TIMER_LO + 8'h0B);
		check("polled count moves", d != d2, 1'b1);
		wr_reg(`REG_TIMER_LO + 8'h03, 8'h02);
		wait_lvl("rtc irq", 2, 1'b0, 500);
		rd_reg(`REG_RTC);
		check("rtc pending", d[1], 1'b1);
		wr_reg(`REG_RTC, 8'h02);
		repeat (2) @(posedge mclk);
		#1;
		check("rtc cleared", processor_irq_n, 1'b1);
		wr_reg(`REG_TIMER_LO + 8'h03, 8'h00);
		$display("test rtc done");

		for (int i = 0; i < 9; i++) begin
			wr_reg(`REG_TIMER_LO + tmr_off[i], 8'h03);
			wait_pulse();
			check("timer map", {7'h00, tout},
				(i == 0) ? 16'h0100 : 16'h0001 << (i - 1));
			wait_pulse();
			check("period", n >= lo && n <= lo + 3, 1'b1);
			wr_reg(`REG_TIMER_LO + tmr_off[i], 8'h00);
		end
		$display("test timers done");

		wr_reg(`REG_BP_CTRL, 8'h01);
		wr_reg(`REG_BP_DATA, 8'hAA);
		wr_reg(`REG_BP_DATA, 8'h55);
		wait_lvl("to host held", 0, 1'b0, 20);
		check("word out", bp_data_out, 16'h55AA);
		check("even word", device_odd_byte, 1'b0);
		check("busy", backplane_ready_n, 1'b1);
		host_channel_model_i.take_word();
		wait_lvl("ready empty", 1, 1'b0, 20);
		check("released", bp_data_oe_n, 1'b1);
		wr_reg(`REG_MEM_CFG, 8'h80);
		repeat (2) @(posedge mclk);
		#1;
		check("dma b req", mem_dma_b_req_n, 1'b0);
		wr_reg(`REG_BP_DATA, 8'h3C);
		wr_reg(`REG_BP_CTRL, 8'h03);
		wait_lvl("odd held", 0, 1'b0, 20);
		check("odd byte", bp_data_out[7:0], 8'h3C);
		check("odd flag", device_odd_byte, 1'b1);
		host_channel_model_i.take_word();
		wr_reg(`REG_MEM_CFG, 8'h00);
		$display("test to host done");

		wr_reg(`REG_BP_CTRL, 8'h00);
		host_channel_model_i.send_word(16'h1234, 1'b0);
		wait_lvl("word in", 1, 1'b0, 20);
		check("irq masked", processor_irq_n, 1'b1);
		wr_reg(`REG_MEM_CFG, 8'h40);
		repeat (2) @(posedge mclk);
		#1;
		check("ext irq", processor_irq_n, 1'b0);
		rd_reg(`REG_BP_DATA);
		check("in low", d, 8'h34);
		rd_reg(`REG_BP_DATA);
		check("in high", d, 8'h12);
		repeat (2) @(posedge mclk);
		#1;
		check("irq gone", processor_irq_n, 1'b1);
		wr_reg(`REG_MEM_CFG, 8'h00);
		host_channel_model_i.send_word(16'hBE77, 1'b1);
		rd_reg(`REG_BP_CTRL);
		check("in odd flag", d[2], 1'b1);
		rd_reg(`REG_BP_DATA);
		check("odd in low", d, 8'h77);
		wait_lvl("odd in done", 1, 1'b1, 4);
		$display("test from host done");

		host_channel_model_i.addr_event(4'h9, 1'b0);
		rd_reg(`REG_BP_ADDR);
		check("addr power on", d, 8'h09);
		host_channel_model_i.addr_event(4'h6, 1'b1);
		rd_reg(`REG_BP_ADDR);
		check("addr clear", d, 8'h06);
		rd_reg(8'h30);
		check("unmapped", d, 8'h00);
		$display("test address done");
		results();
	end
endmodule
